// ==== verilog/efr_bank.sv ====
// Error flag register bank with APB access, sticky flag rules, masks and fatal fault output.
//
// Contract
// - Filter bit 1 hides the error at that position; 0 passes it.
// - Three error filters, each laid out exactly like its error register.
// - Three display filters; a 1 keeps that error out of fatal fault.
// - Three erase filters exist; apart from clock invalid and replace battery, errors clear only through them.
// - Clock invalid sets on time deviation, clears automatically once time is set.
// - Clearing clock invalid by command before time set re-asserts it.
// - Replace battery sets on low backup; clears after replacement and time set.
// - Each watchdog reset counts; at ten the watchdog error flag sets.
// - Watchdog error flag clears only by a communication command.
// - Fraud flag set by tamper, replay, crypto failure; only client clears it.
// - After fraud clear, any new trigger sets it again.
// - Program signature mismatch or missing key sets program memory error.
// - Init RAM test: save, write inverse, compare, restore, compare; mismatch flags.
// - Critical structure signature mismatch on access sets the RAM error flag.
// - NV config checked hourly, dynamic data on access; failure sets NV error.
// - Critical flags (program, RAM, NV, measurement) are never cleared.
// - Any critical flag set also raises the fatal fault indication unless its display filter bit is 1.
// - No response or malformed frame sets that channel's communication error.
// - Slave fraud, permanent error, battery low or valve fault sets channel bit.
// - Failed decryption of a slave frame sets that channel's decryption bit.
// - Error registers are 32 bits, bit 0 least significant.
// - Register 1: bit 0 clock invalid, 11 measurement, 13 fraud.
// - Register 1 bits 16..31: comm, fraud, permanent, battery low per channel.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module efr_bank
  import efr_pkg::*;
#(
  parameter longint NV_PERIOD_CYC = efr_pkg::EFR_NV_PERIOD_CYC
) (
  input  wire logic        pclk,              // APB clock, 100 MHz.
  input  wire logic        presetn,           // Asynchronous reset, active low.
  input  wire logic        psel,              // APB select.
  input  wire logic        penable,           // APB enable.
  input  wire logic        pwrite,            // APB write.
  input  wire logic [7:0]  paddr,             // APB byte address.
  input  wire logic [31:0] pwdata,            // APB write data.
  input  wire logic [3:0]  pstrb,             // APB byte strobes.
  output logic      [31:0] prdata,            // APB read data.
  output logic             pready,            // APB ready.
  output logic             pslverr,           // APB error on unmapped address.
  input  wire logic        clk_deviation,     // Running time deviates from clock structure.
  input  wire logic        time_set,          // Pulse: meter time has been set.
  input  wire logic        batt_low,          // Backup supply below threshold.
  input  wire logic        batt_replaced,     // Pulse: battery replaced.
  input  wire logic        wdog_reset,        // Pulse: watchdog-induced processor reset.
  input  wire logic        cover_open,        // Pulse: terminal cover opened.
  input  wire logic        module_removed,    // Pulse: communication module removed.
  input  wire logic        magnet_detect,     // Pulse: magnetic field detected.
  input  wire logic        replay_attack,     // Pulse: replay attack detected.
  input  wire logic        crypto_fail,       // Pulse: decryption or authentication failure.
  input  wire logic        prog_sig_done,     // Pulse: program signature recomputed.
  input  wire logic        prog_sig_match,    // Signature matched, valid with done.
  input  wire logic        verify_key_present,// Verification key installed.
  input  wire logic        struct_access,     // Pulse: critical data structure accessed.
  input  wire logic        struct_sig_match,  // Structure signature matched, valid with access.
  input  wire logic        nv_cfg_fail,       // Result of hourly NV config check, 1 = bad.
  output logic             nv_cfg_check,      // Pulse: request hourly NV config check.
  input  wire logic        nv_data_access,    // Pulse: dynamic NV data accessed.
  input  wire logic        nv_data_ok,        // Dynamic NV data check passed.
  input  wire logic        meas_fault,        // Pulse: measurement self-check failed.
  input  wire logic [3:0]  mb_no_resp,        // Per channel: slave did not respond.
  input  wire logic [3:0]  mb_bad_frame,      // Per channel: malformed link layer frame.
  input  wire logic [3:0]  mb_fraud,          // Per channel: slave reports fraud.
  input  wire logic [3:0]  mb_perm,           // Per channel: slave reports permanent error.
  input  wire logic [3:0]  mb_batt,           // Per channel: slave reports battery low.
  input  wire logic [3:0]  mb_valve,          // Per channel: slave reports valve fault.
  input  wire logic [3:0]  mb_decr_fail,      // Per channel: frame decryption failed.
  output logic             ram_test_busy,     // Init RAM self-test running.
  output logic             fatal_fault_flag   // Fatal fault indication for the display.
);

  // ==========================================================================
  // Register storage
  // ==========================================================================
  logic [31:0]       err_ff   [EFR_NUM_REGS];
  logic [31:0]       filt_ff  [EFR_NUM_REGS];
  logic [31:0]       disp_ff  [EFR_NUM_REGS];
  logic [31:0]       erase_ff [EFR_NUM_REGS];
  logic [31:0]       nxt_err  [EFR_NUM_REGS];
  logic [31:0]       clr_req  [EFR_NUM_REGS];
  logic [31:0]       set_evt  [EFR_NUM_REGS];
  logic [3:0]        wd_cnt_ff;
  logic              time_valid_ff;
  logic              batt_pend_ff;
  logic              ram_err_evt;
  logic              nv_err_evt;
  logic              prog_err_evt;
  logic [63:0]       nv_tmr_ff;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic              acc;
  logic              wr;
  logic [1:0]        sel_idx;
  logic [3:0]        grp;
  logic              mapped;
  logic [31:0]       rd_val;
  logic [31:0]       wmask;

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign grp     = paddr[7:4];
  assign sel_idx = paddr[3:2];
  assign mapped  = (paddr[1:0] == 2'h0) &&
                   (((grp <= 4'h4) && (sel_idx != 2'h3)) || (paddr == EFR_STAT_OFF));
  assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  always_comb begin
    rd_val = 32'h00000000;
    if (paddr == EFR_STAT_OFF) begin
      rd_val = {22'h000000, ram_test_busy, fatal_fault_flag, 4'h0, wd_cnt_ff};
    end else if (sel_idx != 2'h3) begin
      unique case (grp)
        4'h0: rd_val = err_ff[sel_idx];
        4'h1: rd_val = filt_ff[sel_idx];
        4'h2: rd_val = disp_ff[sel_idx];
        4'h3: rd_val = erase_ff[sel_idx];
        4'h4: rd_val = err_ff[sel_idx] & ~filt_ff[sel_idx];
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  // Zero-wait slave: pready is registered high for the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite & mapped) ? rd_val : 32'h00000000;
    end
  end

  // Masks are plain read/write storage, one per error register.
  generate
    for (genvar i = 0; i < EFR_NUM_REGS; i++) begin : g_mask
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_ff[i]  <= 32'h00000000;
          disp_ff[i]  <= 32'h00000000;
          erase_ff[i] <= 32'h00000000;
        end else if (wr && pready && mapped && sel_idx == 2'(i)) begin
          if (grp == 4'h1) filt_ff[i]  <= (filt_ff[i] & ~wmask) | (pwdata & wmask);
          if (grp == 4'h2) disp_ff[i]  <= (disp_ff[i] & ~wmask) | (pwdata & wmask);
          if (grp == 4'h3) erase_ff[i] <= (erase_ff[i] & ~wmask) | (pwdata & wmask);
        end
      end
      // Writing 1 to an error register clears that bit, subject to the erase filter.
      assign clr_req[i] = (wr && pready && mapped && grp == 4'h0 && sel_idx == 2'(i)) ?
                          (pwdata & wmask & erase_ff[i]) : 32'h00000000;
    end
  endgenerate

  // ==========================================================================
  // Time and battery bookkeeping
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_valid_ff <= 1'b0;
    end else if (time_set) begin
      time_valid_ff <= 1'b1;
    end else if (clk_deviation) begin
      time_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batt_pend_ff <= 1'b0;
    end else if (batt_low) begin
      batt_pend_ff <= 1'b0;
    end else if (batt_replaced) begin
      batt_pend_ff <= 1'b1;
    end else if (time_set) begin
      batt_pend_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Watchdog reset counter
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_ff <= 4'h0;
    end else if (clr_req[0][EFR_B_WDOG]) begin
      wd_cnt_ff <= 4'h0;
    end else if (wdog_reset && wd_cnt_ff != EFR_WD_LIMIT) begin
      wd_cnt_ff <= wd_cnt_ff + 4'h1;
    end
  end

  // ==========================================================================
  // NV hourly check timer
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_tmr_ff    <= 64'h0000000000000000;
      nv_cfg_check <= 1'b0;
    end else if (nv_tmr_ff >= 64'(NV_PERIOD_CYC - 1)) begin
      nv_tmr_ff    <= 64'h0000000000000000;
      nv_cfg_check <= 1'b1;
    end else begin
      nv_tmr_ff    <= nv_tmr_ff + 64'h0000000000000001;
      nv_cfg_check <= 1'b0;
    end
  end

  logic nv_chk_dly_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_chk_dly_ff <= 1'b0;
    end else begin
      nv_chk_dly_ff <= nv_cfg_check;
    end
  end

  // ==========================================================================
  // Init RAM self-test over a local scratch memory
  // ==========================================================================
  efr_rt_state_e          rt_st_ff;
  logic [31:0]            ram_mem [EFR_RAM_DEPTH];
  logic [31:0]            rt_save_ff;
  logic [EFR_RAM_AW-1:0]  rt_addr_ff;
  logic                   rt_fail;

  assign rt_fail = ((rt_st_ff == EFR_RT_CHKI) && (ram_mem[rt_addr_ff] != ~rt_save_ff)) ||
                   ((rt_st_ff == EFR_RT_CHKO) && (ram_mem[rt_addr_ff] != rt_save_ff));

  // The scratch words come up cleared, so the self-test never compares undefined contents.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < EFR_RAM_DEPTH; k++) begin
        ram_mem[k] <= 32'h00000000;
      end
    end else begin
      if (rt_st_ff == EFR_RT_INV) ram_mem[rt_addr_ff] <= ~rt_save_ff;
      if (rt_st_ff == EFR_RT_REST) ram_mem[rt_addr_ff] <= rt_save_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt_st_ff      <= EFR_RT_IDLE;
      rt_addr_ff    <= '0;
      rt_save_ff    <= 32'h00000000;
      ram_test_busy <= 1'b1;
    end else begin
      unique case (rt_st_ff)
        EFR_RT_IDLE: rt_st_ff <= EFR_RT_SAVE;
        EFR_RT_SAVE: begin
          rt_save_ff <= ram_mem[rt_addr_ff];
          rt_st_ff   <= EFR_RT_INV;
        end
        EFR_RT_INV:  rt_st_ff <= EFR_RT_CHKI;
        EFR_RT_CHKI: rt_st_ff <= EFR_RT_REST;
        EFR_RT_REST: rt_st_ff <= EFR_RT_CHKO;
        EFR_RT_CHKO: begin
          rt_addr_ff <= rt_addr_ff + 1'b1;
          rt_st_ff   <= (rt_addr_ff == EFR_RAM_AW'(EFR_RAM_DEPTH - 1)) ? EFR_RT_DONE : EFR_RT_SAVE;
        end
        EFR_RT_DONE: ram_test_busy <= 1'b0;
        default:     rt_st_ff <= EFR_RT_DONE;
      endcase
    end
  end

  // ==========================================================================
  // Error flag set events
  // ==========================================================================
  assign prog_err_evt = (prog_sig_done & ~prog_sig_match) | ~verify_key_present;
  assign ram_err_evt  = rt_fail | (struct_access & ~struct_sig_match);
  assign nv_err_evt   = (nv_chk_dly_ff & nv_cfg_fail) | (nv_data_access & ~nv_data_ok);

  always_comb begin
    set_evt[0] = 32'h00000000;
    set_evt[1] = 32'h00000000;
    set_evt[2] = 32'h00000000;
    set_evt[0][EFR_B_CLK_INV] = clk_deviation | ~time_valid_ff;
    set_evt[0][EFR_B_BATT]    = batt_low;
    set_evt[0][EFR_B_PROG]    = prog_err_evt;
    set_evt[0][EFR_B_RAM]     = ram_err_evt;
    set_evt[0][EFR_B_NVM]     = nv_err_evt;
    set_evt[0][EFR_B_MEAS]    = meas_fault;
    set_evt[0][EFR_B_WDOG]    = wdog_reset && (wd_cnt_ff == EFR_WD_LIMIT - 4'h1);
    set_evt[0][EFR_B_FRAUD]   = cover_open | module_removed | magnet_detect |
                                replay_attack | crypto_fail;
    set_evt[0][EFR_B_MB_COMM  +: EFR_NUM_CH] = mb_no_resp | mb_bad_frame;
    set_evt[0][EFR_B_MB_FRAUD +: EFR_NUM_CH] = mb_fraud;
    set_evt[0][EFR_B_MB_PERM  +: EFR_NUM_CH] = mb_perm;
    set_evt[0][EFR_B_MB_BATT  +: EFR_NUM_CH] = mb_batt;
    set_evt[1][EFR_B_MB_DECR  +: EFR_NUM_CH] = mb_decr_fail;
    set_evt[1][EFR_B_MB_VALVE +: EFR_NUM_CH] = mb_valve;
  end

  // Set wins over clear; critical bits ignore clears; hardware clears two bits itself.
  always_comb begin
    for (int i = 0; i < EFR_NUM_REGS; i++) begin
      nxt_err[i] = (err_ff[i] & ~clr_req[i]) | set_evt[i];
    end
    nxt_err[0] = nxt_err[0] | (err_ff[0] & EFR_CRIT_MASK);
    if (time_set && !clk_deviation) nxt_err[0][EFR_B_CLK_INV] = 1'b0;
    if (batt_pend_ff && time_set && !batt_low) nxt_err[0][EFR_B_BATT] = 1'b0;
    if (!clr_req[0][EFR_B_WDOG] && err_ff[0][EFR_B_WDOG]) nxt_err[0][EFR_B_WDOG] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff[0] <= EFR_RST_ZERO;
      err_ff[1] <= EFR_RST_ZERO;
      err_ff[2] <= EFR_RST_ZERO;
    end else begin
      err_ff[0] <= nxt_err[0];
      err_ff[1] <= nxt_err[1];
      err_ff[2] <= nxt_err[2];
    end
  end

  // ==========================================================================
  // Fatal fault indication
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fatal_fault_flag <= 1'b0;
    end else begin
      fatal_fault_flag <= |(err_ff[0] & EFR_CRIT_MASK & ~disp_ff[0]);
    end
  end

endmodule

// ==== verilog/efr_pkg.sv ====
// Package with register map, bit positions and constants for the error flag register bank.
package efr_pkg;

  localparam int          EFR_NUM_REGS   = 3;
  localparam int          EFR_NUM_CH     = 4;
  localparam int          EFR_WD_LIMIT_I = 10;
  localparam logic [3:0]  EFR_WD_LIMIT   = 4'hA;

  // Register byte offsets.
  localparam logic [7:0]  EFR_ERR1_OFF   = 8'h00;
  localparam logic [7:0]  EFR_ERR2_OFF   = 8'h04;
  localparam logic [7:0]  EFR_ERR3_OFF   = 8'h08;
  localparam logic [7:0]  EFR_FILT1_OFF  = 8'h10;
  localparam logic [7:0]  EFR_FILT2_OFF  = 8'h14;
  localparam logic [7:0]  EFR_FILT3_OFF  = 8'h18;
  localparam logic [7:0]  EFR_DISP1_OFF  = 8'h20;
  localparam logic [7:0]  EFR_DISP2_OFF  = 8'h24;
  localparam logic [7:0]  EFR_DISP3_OFF  = 8'h28;
  localparam logic [7:0]  EFR_ERASE1_OFF = 8'h30;
  localparam logic [7:0]  EFR_ERASE2_OFF = 8'h34;
  localparam logic [7:0]  EFR_ERASE3_OFF = 8'h38;
  localparam logic [7:0]  EFR_REP1_OFF   = 8'h40;
  localparam logic [7:0]  EFR_REP2_OFF   = 8'h44;
  localparam logic [7:0]  EFR_REP3_OFF   = 8'h48;
  localparam logic [7:0]  EFR_STAT_OFF   = 8'h50;

  // Error register 1 bit positions.
  localparam int          EFR_B_CLK_INV  = 0;
  localparam int          EFR_B_BATT     = 1;
  localparam int          EFR_B_PROG     = 8;
  localparam int          EFR_B_RAM      = 9;
  localparam int          EFR_B_NVM      = 10;
  localparam int          EFR_B_MEAS     = 11;
  localparam int          EFR_B_WDOG     = 12;
  localparam int          EFR_B_FRAUD    = 13;
  localparam int          EFR_B_MB_COMM  = 16;
  localparam int          EFR_B_MB_FRAUD = 20;
  localparam int          EFR_B_MB_PERM  = 24;
  localparam int          EFR_B_MB_BATT  = 28;
  // Error register 2 bit positions.
  localparam int          EFR_B_MB_DECR  = 23;
  localparam int          EFR_B_MB_VALVE = 27;

  // Critical bits of error register 1: program, RAM, NV memory, measurement.
  localparam logic [31:0] EFR_CRIT_MASK  = 32'h00000F00;
  // Value of every error register after reset.
  localparam logic [31:0] EFR_RST_ZERO   = 32'h00000000;

  // NV configuration check period.
  localparam int          EFR_NV_PERIOD_S  = 3600;
  localparam int          EFR_CLK_HZ       = 100000000;
  localparam longint      EFR_NV_PERIOD_CYC = longint'(EFR_NV_PERIOD_S) * longint'(EFR_CLK_HZ);

  // RAM self-test sequencer states.
  typedef enum logic [2:0] {
    EFR_RT_IDLE  = 3'b000,
    EFR_RT_SAVE  = 3'b001,
    EFR_RT_INV   = 3'b010,
    EFR_RT_CHKI  = 3'b011,
    EFR_RT_REST  = 3'b100,
    EFR_RT_CHKO  = 3'b101,
    EFR_RT_DONE  = 3'b110
  } efr_rt_state_e;

  localparam int          EFR_RAM_AW     = 4;
  localparam int          EFR_RAM_DEPTH  = 16;

endpackage

// ==== dv/efr_bank_asserts.sv ====
// Port assertions for the error flag register bank.
`timescale 1ns/1ps
module efr_bank_chk #(
  parameter longint NV_PERIOD_CYC = 50
) (
  input wire logic        pclk,          // Clock.
  input wire logic        presetn,       // Reset, low.
  input wire logic        psel,          // Select.
  input wire logic        penable,       // Access.
  input wire logic [7:0]  paddr,         // Address.
  input wire logic [31:0] prdata,        // Read data.
  input wire logic        pready,        // Ready.
  input wire logic        pslverr,       // Error.
  input wire logic        nv_cfg_check,  // Check request.
  input wire logic        ram_test_busy  // Self-test.
);
  logic [31:0] nv_cnt_ff;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the last check request; zero until the first one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nv_cnt_ff <= 32'h00000000;
    else if (nv_cfg_check) nv_cnt_ff <= 32'h00000001;
    else if (nv_cnt_ff != 32'h00000000) nv_cnt_ff <= nv_cnt_ff + 32'h00000001;
  end
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("ready late");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h00000000) else $error("stray data");
  a_unaligned_err: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
    else $error("unaligned accepted");
  a_err_regs_ok: assert property (psel && !penable && paddr inside {8'h00, 8'h04, 8'h08} |=> !pslverr)
    else $error("error register refused");
  a_test_stays_done: assert property (!ram_test_busy |=> !ram_test_busy) else $error("test restarted");
  a_nv_period_exact: assert property (nv_cfg_check && nv_cnt_ff != 32'h0 |-> nv_cnt_ff == 32'(NV_PERIOD_CYC))
    else $error("check period");
  a_nv_no_overdue: assert property (nv_cnt_ff <= 32'(NV_PERIOD_CYC)) else $error("check overdue");
endmodule
bind efr_bank efr_bank_chk #(.NV_PERIOD_CYC(NV_PERIOD_CYC)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .nv_cfg_check(nv_cfg_check), .ram_test_busy(ram_test_busy));

// ==== dv/efr_client.sv ====
// Management client model: an APB master that reads and clears flags.
`timescale 1ns/1ps
module efr_client (
  input  wire logic        pclk,    // Clock.
  output logic             psel,    // Select.
  output logic             penable, // Access.
  output logic             pwrite,  // Write.
  output logic [7:0]       paddr,   // Address.
  output logic [31:0]      pwdata,  // Write data.
  output logic [3:0]       pstrb,   // Strobes.
  input  wire logic [31:0] prdata,  // Read data.
  input  wire logic        pready,  // Ready.
  input  wire logic        pslverr  // Error.
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b000, 8'h00, 32'h0, 4'hF};
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the error flag register bank.
`timescale 1ns/1ps
module tb_top;
  typedef struct { int idx; logic [7:0] off; logic [31:0] val; } efr_row_s;
  localparam longint NV_CYC = 50;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_deviation = 1'b0;
  logic        batt_low = 1'b0;
  logic        nv_fail = 1'b0;
  logic        key_ok = 1'b1;
  // Pulses: 0-4 fraud, 5 measure, 6 watchdog, 7 structure, 8 NV data, 9 program, 10 time, 11 battery, 12+ bus.
  logic [39:0] ev = 40'h0;
  logic        psel, penable, pwrite, pready, pslverr, err, nv_cfg_check, ram_test_busy, fatal_fault_flag;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count = 0;
  int          checked = 0;
  efr_row_s    rows [16] = '{'{0, 8'h00, 32'h2000}, '{1, 8'h00, 32'h2000}, '{2, 8'h00, 32'h2000},
    '{3, 8'h00, 32'h2000}, '{4, 8'h00, 32'h2000}, '{12, 8'h00, 32'h10000}, '{19, 8'h00, 32'h80000},
    '{21, 8'h00, 32'h200000}, '{26, 8'h00, 32'h4000000}, '{31, 8'h00, 32'h80000000},
    '{32, 8'h04, 32'h8000000}, '{38, 8'h04, 32'h2000000}, '{9, 8'h00, 32'h100},
    '{7, 8'h00, 32'h300}, '{8, 8'h00, 32'h700}, '{5, 8'h00, 32'hF00}};
  always #5 pclk = ~pclk;
  efr_bank #(.NV_PERIOD_CYC(NV_CYC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_deviation(clk_deviation), .time_set(ev[10]), .batt_low(batt_low),
    .batt_replaced(ev[11]), .wdog_reset(ev[6]), .cover_open(ev[0]), .module_removed(ev[1]),
    .magnet_detect(ev[2]), .replay_attack(ev[3]), .crypto_fail(ev[4]), .prog_sig_done(ev[9]),
    .prog_sig_match(1'b0), .verify_key_present(key_ok), .struct_access(ev[7]), .struct_sig_match(1'b0),
    .nv_cfg_fail(nv_fail), .nv_cfg_check(nv_cfg_check), .nv_data_access(ev[8]), .nv_data_ok(1'b0),
    .meas_fault(ev[5]), .mb_no_resp(ev[15:12]), .mb_bad_frame(ev[19:16]), .mb_fraud(ev[23:20]),
    .mb_perm(ev[27:24]), .mb_batt(ev[31:28]), .mb_valve(ev[35:32]), .mb_decr_fail(ev[39:36]),
    .ram_test_busy(ram_test_busy), .fatal_fault_flag(fatal_fault_flag));
  efr_client u_cli (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_cli.xfer(w, a, d, rd, err);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= 40'h0;
    @(posedge pclk);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 300 && ram_test_busy !== 1'b0; n++) @(posedge pclk);
    chk({31'h0, ram_test_busy}, 32'h0);
  endtask
  task automatic give_verdict();
    $display("checked %0d, bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    rw(1'b1, 8'h30, 32'hFFFFFFFF);
    rw(1'b1, 8'h34, 32'hFFFFFFFF);
    pulse(10);
    foreach (rows[i]) begin
      rw(1'b1, rows[i].off, 32'hFFFFFFFF);
      pulse(rows[i].idx);
      rw(1'b0, rows[i].off, 32'h0);
      chk(rd, rows[i].val);
    end
    $display("event rows done");
    chk({31'h0, fatal_fault_flag}, 32'h1);
    rw(1'b1, 8'h20, 32'hF00);
    repeat (2) @(posedge pclk);
    chk({31'h0, fatal_fault_flag}, 32'h0);
    rw(1'b1, 8'h20, 32'h700);
    repeat (2) @(posedge pclk);
    chk({31'h0, fatal_fault_flag}, 32'h1);
    $display("fatal test done");
    rw(1'b1, 8'h10, 32'h300);
    rw(1'b1, 8'h40, 32'h0);
    rw(1'b0, 8'h40, 32'h0);
    chk(rd, 32'hC00);
    rw(1'b1, 8'h14, 32'h2000000);
    rw(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h0);
    rw(1'b0, 8'h0C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("filter test done");
    clk_deviation <= 1'b1;
    @(posedge pclk);
    clk_deviation <= 1'b0;
    rw(1'b1, 8'h00, 32'h1);
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hF01);
    pulse(10);
    batt_low <= 1'b1;
    @(posedge pclk);
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hF02);
    batt_low <= 1'b0;
    pulse(10);
    pulse(11);
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hF02);
    pulse(10);
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hF00);
    $display("clock and battery test done");
    repeat (9) pulse(6);
    rw(1'b0, 8'h50, 32'h0);
    chk(rd & 32'hF, 32'h9);
    pulse(6);
    pulse(10);
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1F00);
    rw(1'b1, 8'h00, 32'h1000);
    rw(1'b0, 8'h50, 32'h0);
    chk(rd & 32'hF, 32'h0);
    rw(1'b1, 8'h30, 32'h0);
    pulse(0);
    rw(1'b1, 8'h00, 32'hFFFFFFFF);
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2F00);
    $display("watchdog and erase test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({30'h0, ram_test_busy, fatal_fault_flag}, 32'h2);
    presetn <= 1'b1;
    wait_idle();
    for (int a = 16; a < 64; a += 4) begin
      rw(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
    end
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    $display("reset test done");
    nv_fail <= 1'b1;
    repeat (60) @(posedge pclk);
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h401);
    key_ok <= 1'b0;
    @(posedge pclk);
    rw(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h501);
    $display("memory check test done");
    give_verdict();
  end
endmodule
